// [design/scp_pkg.sv]
// shared constants for the serial configuration port
package scp_pkg;
  localparam int          INSTR_BITS     = 16;
  localparam int          ADDR_BITS      = 13;
  localparam int          RW_BIT         = 15;  // 1 = read
  localparam int          WL_HI_BIT      = 14;
  localparam int          WL_LO_BIT      = 13;
  localparam logic [1:0]  WL_STREAM      = 2'h3;
  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_ID   = 13'h0001;
  localparam logic [12:0] ADDR_GRADE     = 13'h0002;
  localparam logic [12:0] ADDR_INDEX_2   = 13'h0004;
  localparam logic [12:0] ADDR_INDEX_1   = 13'h0005;
  localparam logic [12:0] ADDR_FUNC_LO   = 13'h0008;
  localparam logic [12:0] ADDR_FUNC_HI   = 13'h002D;
  localparam logic [12:0] ADDR_CLK_CFG   = 13'h0009;
  localparam logic [12:0] ADDR_UPDATE    = 13'h00FF;
  localparam logic [7:0]  UPDATE_CMD     = 8'h01;
  localparam logic [7:0]  RST_PORT_CFG   = 8'h18;
  localparam logic [7:0]  RST_GRADE      = 8'h00;
  localparam logic [7:0]  RST_INDEX      = 8'h0F;
  localparam logic [7:0]  RST_CLK_CFG    = 8'h01;
  localparam logic [7:0]  RST_FUNC       = 8'h00;
  localparam int          LSB_FIRST_BIT  = 6;
  localparam int          LSB_FIRST_MIR  = 1;
  localparam int          SOFT_RST_BIT   = 5;
  localparam int          SOFT_RST_MIR   = 2;
  // byte offsets of the controller's apb registers
  localparam logic [11:0] OFF_CMD        = 12'h000;
  localparam logic [11:0] OFF_WDATA      = 12'h004;
  localparam logic [11:0] OFF_STATUS     = 12'h008;
  localparam logic [11:0] OFF_RDATA      = 12'h00C;
  localparam logic [11:0] OFF_CFG        = 12'h010;
  localparam int          CLK_DIV_DEF    = 4;   // half link period in clk_i
endpackage

// [design/scp_if.sv]
// link wires between the configuration port and its controller
`timescale 1ns/1ps
interface scp_if;
  logic sclk;
  logic chip_select_n;
  logic sdio_m_o;   // controller drive value
  logic sdio_m_oe;  // controller drives
  logic sdio_d_o;   // device drive value
  logic sdio_d_oe;  // device drives
  wire  sdio = sdio_m_oe ? sdio_m_o : (sdio_d_oe ? sdio_d_o : 1'b0);
  modport dev (input sclk, chip_select_n, sdio, output sdio_d_o, sdio_d_oe);
  modport ctl (output sclk, chip_select_n, sdio_m_o, sdio_m_oe, input sdio);
endinterface

// [design/scp_device.sv]
// configuration port device end: serial decoder and register bank
// What this block does
// - frame starts at select low then clock rise
// - sixteen bit instruction, then data bytes
// - ignore clock and data while deselected
// - select may rise between bytes of a counted frame, keep position
// - length code 11 streams until deselect
// - deselect mid byte resets serial state
// - select tied low gives two wire mode
// - two wire mode uses fixed length transfers
// - never request streaming in two wire mode
// - read turns data pin to output after instruction
// - msb first by default, lsb first selectable
// - clock and select inputs, data two way
// - data sampled on serial clock rising edge
// - drive after fall, release after rise
// - buffered registers except config, grade, index, update
// - writing 01 to update copies pending values
// - clock register bit0 stabilizer, resets to 01
// - config 00-02, index 04,05,ff, functions 08-2d
// - byte registers, written and read back
// - defaults loaded on reset
// - master writes zero to reserved bits
`timescale 1ns/1ps
module scp_device #(
  parameter logic [7:0] CHIP_ID = 8'h5A  // arbitrary identity value
) (
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  scp_if.dev         lnk,
  output logic [7:0] clk_cfg_o,       // active clock register
  output logic [7:0] port_cfg_o,
  output logic       stabilizer_en_o
);
  localparam int NFUNC = 38;  // 0x08..0x2d

  // two-flop synchronisers for link inputs
  logic [1:0] sclk_s_q, csn_s_q, sdi_s_q;
  logic       sclk_d1_q;
  always_ff @(posedge clk_i)
  begin
    sclk_s_q  <= {sclk_s_q[0], lnk.sclk};
    csn_s_q   <= {csn_s_q[0], lnk.chip_select_n};
    sdi_s_q   <= {sdi_s_q[0], lnk.sdio};
    sclk_d1_q <= sclk_s_q[1];
  end
  wire csn  = csn_s_q[1];
  wire sdi  = sdi_s_q[1];
  wire rise = sclk_s_q[1] & ~sclk_d1_q & ~csn;
  wire fall = ~sclk_s_q[1] & sclk_d1_q & ~csn;

  // serial state
  logic [15:0] ins_q;
  logic [4:0]  icnt_q;      // instruction bits taken
  logic [2:0]  bcnt_q;      // bit within data byte
  logic [1:0]  left_q;      // bytes remaining minus one
  logic [12:0] addr_q;
  logic [7:0]  sh_q;
  logic        drv_q, sdo_q;
  logic [7:0]  port_q, grade_q, idx2_q, idx1_q;
  logic [7:0]  act_q [NFUNC];
  logic [7:0]  pend_q [NFUNC];

  wire        lsb_first = port_q[scp_pkg::LSB_FIRST_BIT]
                        | port_q[scp_pkg::LSB_FIRST_MIR];
  wire        ins_done  = (icnt_q == 5'(scp_pkg::INSTR_BITS));
  wire        is_read   = ins_q[scp_pkg::RW_BIT];
  wire [1:0]  wl        = ins_q[scp_pkg::WL_HI_BIT:scp_pkg::WL_LO_BIT];
  wire        stream    = (wl == scp_pkg::WL_STREAM);
  wire        mid_byte  = ins_done ? (bcnt_q != 3'h0) : (icnt_q != 5'h0);
  // a streaming frame has no counted end, so deselect always closes it
  wire        abort     = csn & (mid_byte
                        | (ins_done & stream));
  wire        in_func   = (addr_q >= scp_pkg::ADDR_FUNC_LO)
                        & (addr_q <= scp_pkg::ADDR_FUNC_HI);
  wire [5:0]  fidx      = 6'(addr_q - scp_pkg::ADDR_FUNC_LO);
  wire [7:0]  wbyte     = lsb_first ? {sdi, sh_q[7:1]} : {sh_q[6:0], sdi};
  wire        byte_end  = ins_done & rise & (bcnt_q == 3'h7);
  wire        wr_stb    = byte_end & ~is_read;
  wire        upd_stb   = wr_stb & (addr_q == scp_pkg::ADDR_UPDATE)
                        & (wbyte == scp_pkg::UPDATE_CMD);
  wire        soft_rst  = wr_stb & (addr_q == scp_pkg::ADDR_PORT_CFG)
                        & (wbyte[scp_pkg::SOFT_RST_BIT]
                        | wbyte[scp_pkg::SOFT_RST_MIR]);
  wire        last_byte = ~stream & (left_q == 2'h0);

  // readback mux over the byte map
  function automatic logic [7:0] rd_byte(input logic [12:0] a);
    logic [5:0] i;
    i = 6'(a - scp_pkg::ADDR_FUNC_LO);
    case (a)
      scp_pkg::ADDR_PORT_CFG: rd_byte = port_q;
      scp_pkg::ADDR_CHIP_ID:  rd_byte = CHIP_ID;
      scp_pkg::ADDR_GRADE:    rd_byte = grade_q;
      scp_pkg::ADDR_INDEX_2:  rd_byte = idx2_q;
      scp_pkg::ADDR_INDEX_1:  rd_byte = idx1_q;
      default:
        rd_byte = ((a >= scp_pkg::ADDR_FUNC_LO)
                 & (a <= scp_pkg::ADDR_FUNC_HI)) ? pend_q[i] : 8'h00;
    endcase
  endfunction
  wire [7:0] rdat = rd_byte(addr_q);

  // instruction shifting, frame position and address advance
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || abort || soft_rst)
    begin
      icnt_q <= 5'h0;
      bcnt_q <= 3'h0;
      ins_q  <= 16'h0000;
      left_q <= 2'h0;
      addr_q <= 13'h0000;
      sh_q   <= 8'h00;
    end
    else if (rise && !ins_done)
    begin
      ins_q  <= {ins_q[14:0], sdi};
      icnt_q <= icnt_q + 5'h1;
      if (icnt_q == 5'(scp_pkg::INSTR_BITS - 1))
      begin
        addr_q <= {ins_q[11:0], sdi};
        left_q <= ins_q[13:12];
        sh_q   <= rd_byte({ins_q[11:0], sdi});
      end
    end
    else if (rise)
    begin
      bcnt_q <= bcnt_q + 3'h1;
      // readback indexes an unshifted byte, so only writes shift
      if (!is_read)
        sh_q <= lsb_first ? {sdi, sh_q[7:1]} : {sh_q[6:0], sdi};
      if (bcnt_q == 3'h7)
      begin
        if (last_byte)
          icnt_q <= 5'h0;  // frame over, next bits are a new instruction
        left_q <= left_q - 2'h1;
        addr_q <= addr_q + 13'h1;
        sh_q   <= rd_byte(addr_q + 13'h1);
      end
    end
  end

  // data pin drive: enable on fall, release on rise after last bit
  wire [2:0] tx_pos = lsb_first ? bcnt_q : 3'(3'h7 - bcnt_q);
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || csn)
    begin
      drv_q <= 1'b0;
      sdo_q <= 1'b0;
    end
    else if (fall && ins_done && is_read)
    begin
      drv_q <= 1'b1;
      sdo_q <= sh_q[tx_pos];
    end
    else if (rise && (!ins_done || !is_read ||
             (bcnt_q == 3'h7 && last_byte)))
      drv_q <= 1'b0;
  end
  assign lnk.sdio_d_o  = sdo_q;
  assign lnk.sdio_d_oe = drv_q;

  // immediate registers: port config, grade, index
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      port_q  <= scp_pkg::RST_PORT_CFG;
      grade_q <= scp_pkg::RST_GRADE;
      idx2_q  <= scp_pkg::RST_INDEX;
      idx1_q  <= scp_pkg::RST_INDEX;
    end
    else if (wr_stb)
    begin
      case (addr_q)
        scp_pkg::ADDR_PORT_CFG: port_q  <= (wbyte & 8'h66)
                                         | scp_pkg::RST_PORT_CFG;  // fixed ones
        scp_pkg::ADDR_GRADE:    grade_q <= wbyte & 8'h30;
        scp_pkg::ADDR_INDEX_2:  idx2_q  <= wbyte & 8'h0F;
        scp_pkg::ADDR_INDEX_1:  idx1_q  <= wbyte & 8'h3F;
        default:                ;
      endcase
    end
  end

  // buffered function registers: pending and active copies
  genvar g;
  generate
    for (g = 0; g < NFUNC; g++)
    begin : g_func
      localparam logic [7:0] RV = (g == int'(scp_pkg::ADDR_CLK_CFG
                                - scp_pkg::ADDR_FUNC_LO))
                                ? scp_pkg::RST_CLK_CFG : scp_pkg::RST_FUNC;
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
        begin
          pend_q[g] <= RV;
          act_q[g]  <= RV;
        end
        else
        begin
          if (wr_stb && in_func && fidx == 6'(g))
            pend_q[g] <= wbyte;
          if (upd_stb)
            act_q[g] <= pend_q[g];
        end
      end
    end
  endgenerate

  // active outputs
  localparam int CLKI = int'(scp_pkg::ADDR_CLK_CFG - scp_pkg::ADDR_FUNC_LO);
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      clk_cfg_o       <= scp_pkg::RST_CLK_CFG;
      port_cfg_o      <= scp_pkg::RST_PORT_CFG;
      stabilizer_en_o <= 1'b1;
    end
    else
    begin
      clk_cfg_o       <= act_q[CLKI];
      port_cfg_o      <= port_q;
      stabilizer_en_o <= act_q[CLKI][0];
    end
  end
endmodule

// [design/scp_ctrl.sv]
// configuration port controller end: apb slave driving the serial link
`timescale 1ns/1ps
module scp_ctrl #(
  parameter int CLK_DIV = scp_pkg::CLK_DIV_DEF  // clk_i per half link period
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  scp_if.ctl               lnk
);
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_LOW  = 2'b01,
    SC_HIGH = 2'b10,
    SC_END  = 2'b11
  } scp_state_e;

  scp_state_e  st_q;
  logic [15:0] cmd_q;      // rw, length, address
  logic [23:0] wd_q;       // up to three write bytes, first in [23:16]
  logic [23:0] rd_q;
  logic        lsb_q;      // send data lsb first
  logic [5:0]  bit_q;      // bits left in frame
  logic [39:0] sh_q;
  logic [7:0]  div_q;
  logic        sclk_q, csn_q, mo_q, moe_q, busy_q;
  logic [1:0]  sdi_s_q;
  logic [31:0] prd_q;
  logic        rdy_q, err_q;

  wire tick  = (div_q == 8'(CLK_DIV - 1));
  wire acc   = psel_i & penable_i & ~rdy_q;
  wire wr    = acc & pwrite_i;
  wire start = wr & (paddr_i == scp_pkg::OFF_CMD) & ~busy_q;
  wire known = (paddr_i == scp_pkg::OFF_CMD)
             | (paddr_i == scp_pkg::OFF_WDATA)
             | (paddr_i == scp_pkg::OFF_STATUS)
             | (paddr_i == scp_pkg::OFF_RDATA)
             | (paddr_i == scp_pkg::OFF_CFG);
  // a streaming length code is sent as one byte so frames always end on a counted byte
  wire [1:0] wl     = pwdata_i[14:13];
  wire [1:0] nbytes = (wl == scp_pkg::WL_STREAM) ? 2'h0 : wl;
  wire [5:0] nbits  = 6'(16 + 8 * (int'(nbytes) + 1));
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7 - i];
  endfunction
  wire [23:0] wd_send = lsb_q ? {rev8(wd_q[23:16]), rev8(wd_q[15:8]),
                                 rev8(wd_q[7:0])} : wd_q;
  wire [23:0] rd_show = lsb_q ? {rev8(rd_q[23:16]), rev8(rd_q[15:8]),
                                 rev8(rd_q[7:0])} : rd_q;
  // last instruction bit of a read: the device takes the line after it
  wire [5:0]  rd_turn = 6'(8 * (int'(cmd_q[14:13]) + 1) + 1);
  wire        turn    = cmd_q[15] & (bit_q == rd_turn);

  // apb slave, one wait cycle per access
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      prd_q <= 32'h0000_0000;
      wd_q  <= 24'h000000;
      lsb_q <= 1'b0;
    end
    else
    begin
      rdy_q <= acc;
      err_q <= acc & (~known | (wr & (paddr_i == scp_pkg::OFF_CMD) & busy_q));
      if (wr && paddr_i == scp_pkg::OFF_WDATA)
        wd_q <= pwdata_i[23:0];
      if (wr && paddr_i == scp_pkg::OFF_CFG)
        lsb_q <= pwdata_i[0];
      case (paddr_i)
        scp_pkg::OFF_STATUS: prd_q <= {31'h0, busy_q};
        scp_pkg::OFF_RDATA:  prd_q <= {8'h00, rd_show};
        scp_pkg::OFF_CFG:    prd_q <= {31'h0, lsb_q};
        scp_pkg::OFF_CMD:    prd_q <= {16'h0000, cmd_q};
        default:             prd_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata_o  = prd_q;
  assign pready_o  = rdy_q;
  assign pslverr_o = err_q;

  // frame engine: select low, sixteen instruction bits, data bytes
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_q    <= SC_IDLE;
      sclk_q  <= 1'b0;
      csn_q   <= 1'b1;
      moe_q   <= 1'b0;
      mo_q    <= 1'b0;
      busy_q  <= 1'b0;
      div_q   <= 8'h00;
      bit_q   <= 6'h00;
      sh_q    <= 40'h0;
      cmd_q   <= 16'h0000;
      rd_q    <= 24'h000000;
      sdi_s_q <= 2'b00;
    end
    else
    begin
      sdi_s_q <= {sdi_s_q[0], lnk.sdio};
      div_q   <= (tick || st_q == SC_IDLE) ? 8'h00 : div_q + 8'h01;
      case (st_q)
        SC_IDLE:
          if (start)
          begin
            cmd_q  <= {pwdata_i[15], nbytes, pwdata_i[12:0]};
            sh_q   <= {pwdata_i[15], nbytes, pwdata_i[12:0], wd_send};
            bit_q  <= nbits;
            busy_q <= 1'b1;
            csn_q  <= 1'b0;
            mo_q   <= pwdata_i[15];  // first bit set up before any rise
            moe_q  <= 1'b1;
            rd_q   <= 24'h000000;
            st_q   <= SC_LOW;
          end
        SC_LOW:
          if (tick)  // bit has stood a half period
          begin
            sclk_q <= 1'b1;
            st_q   <= SC_HIGH;
          end
        SC_HIGH:
          if (tick)
          begin
            sclk_q <= 1'b0;
            sh_q   <= {sh_q[38:0], 1'b0};
            mo_q   <= sh_q[38];  // next bit a half period ahead of rise
            if (turn)
              moe_q <= 1'b0;  // release on this fall, before device drives
            if (!moe_q)
              rd_q <= {rd_q[22:0], sdi_s_q[1]};
            bit_q  <= bit_q - 6'h01;
            st_q   <= (bit_q == 6'h01) ? SC_END : SC_LOW;
          end
        SC_END:
          if (tick)
          begin
            csn_q  <= 1'b1;
            moe_q  <= 1'b0;
            busy_q <= 1'b0;
            st_q   <= SC_IDLE;
          end
        default:
          st_q <= SC_IDLE;
      endcase
    end
  end
  assign lnk.sclk          = sclk_q;
  assign lnk.chip_select_n = csn_q;
  assign lnk.sdio_m_o      = mo_q;
  assign lnk.sdio_m_oe     = moe_q;
endmodule

// [testbench/scp_properties.sv]
// link checker for the configuration port pair
`timescale 1ns/1ps
module scp_properties (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdio_m_o,
  input wire logic sdio_m_oe,
  input wire logic sdio_d_o,
  input wire logic sdio_d_oe,
  input wire logic sdio
);
  logic       sclk_q;
  logic [7:0] rises_q;
  logic [7:0] rises_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // serial clock rises seen in the current frame
  assign rises_d = chip_select_n ? 8'h00
                 : rises_q + {7'h00, sclk & ~sclk_q};
  always_ff @(posedge clk_i)
  begin
    sclk_q  <= rstn_i & sclk;
    rises_q <= rstn_i ? rises_d : 8'h00;
  end
  // one link clock phase is four system clocks
  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low_phase;
    !sclk [*4];
  endsequence
  chk_no_contention: assert property (!(sdio_m_oe && sdio_d_oe))
    else $error("both ends drive the data line");
  chk_high_phase: assert property ($rose(sclk) |-> s_high_phase)
    else $error("link clock high phase wrong");
  chk_low_phase: assert property
    ($fell(sclk) && !chip_select_n |-> s_low_phase)
    else $error("link clock low phase wrong");
  chk_idle_clock: assert property (chip_select_n |-> !sclk)
    else $error("link clock runs while deselected");
  chk_frame_start: assert property
    ($fell(chip_select_n) |-> !sclk ##[1:12] $rose(sclk))
    else $error("frame start not followed by clock rise");
  chk_data_hold: assert property
    ($past(sclk) && sclk && sdio_m_oe |-> $stable(sdio_m_o))
    else $error("controller data moved while clock high");
  chk_read_hold: assert property
    ($past(sclk) && sclk && $past(sdio_d_oe) && sdio_d_oe
     |-> $stable(sdio_d_o))
    else $error("readback data moved while clock high");
  chk_oe_after_instr: assert property
    ($rose(sdio_d_oe) |-> rises_q == 8'h10 && !sclk)
    else $error("readback enabled off the instruction end");
  chk_oe_release: assert property
    ($fell(sdio_d_oe) |-> rises_q inside {8'h18, 8'h20, 8'h28})
    else $error("readback released before the last byte");
  chk_release_desel: assert property (chip_select_n |-> !sdio_d_oe)
    else $error("device drives while deselected");
  chk_frame_bits: assert property
    ($rose(chip_select_n) |-> rises_q inside {8'h18, 8'h20, 8'h28})
    else $error("frame bit count wrong");
endmodule

// [testbench/test_serial_config_port.sv]
// bench for the configuration port controller and device pair
`timescale 1ns/1ps
module test_serial_config_port;
  localparam logic [7:0] ID = 8'h5C;  // arbitrary identity value
  logic        clk_i;
  logic        rstn_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  clk_cfg_o;
  logic [7:0]  port_cfg_o;
  logic        stab_o;
  logic [7:0]  clk_cfg2;
  logic        stab2;
  logic [7:0]  mem [0:63];
  logic [31:0] q;
  logic [31:0] r;
  logic [12:0] a;
  logic        e;
  int          nb;
  int          n_fail;
  int          compares;
  int          seed;
  scp_if lnk ();
  scp_if lnk2 ();
  // pair under test, a second device on a bench driven link
  scp_ctrl scp_ctrl_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .lnk(lnk.ctl));
  scp_device #(.CHIP_ID(ID)) scp_device_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .lnk(lnk.dev), .clk_cfg_o(clk_cfg_o),
    .port_cfg_o(port_cfg_o), .stabilizer_en_o(stab_o));
  scp_device #(.CHIP_ID(ID)) scp_device_inst2 (.clk_i(clk_i),
    .rstn_i(rstn_i), .lnk(lnk2.dev), .clk_cfg_o(clk_cfg2),
    .port_cfg_o(), .stabilizer_en_o(stab2));
  scp_properties scp_properties_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .sclk(lnk.sclk), .chip_select_n(lnk.chip_select_n),
    .sdio_m_o(lnk.sdio_m_o), .sdio_m_oe(lnk.sdio_m_oe),
    .sdio_d_o(lnk.sdio_d_o), .sdio_d_oe(lnk.sdio_d_oe), .sdio(lnk.sdio));
  // 25 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic results();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(input logic ok);
    if (!ok)
    begin
      n_fail++;
      results();
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    bound(pready_o === 1'b1);
    @(posedge clk_i);
  endtask
  // one link frame through the controller, waits for busy to clear
  task automatic xfer(input logic rd, input logic [1:0] wl,
                      input logic [12:0] ad, input logic [23:0] d);
    int n;
    if (!rd)
      apb(1'b1, scp_pkg::OFF_WDATA, {8'h00, d});
    apb(1'b1, scp_pkg::OFF_CMD, {16'h0000, rd, wl, ad});
    n = 0;
    do
    begin
      apb(1'b0, scp_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 200);
    bound(q[0] === 1'b0);
    if (rd)
      apb(1'b0, scp_pkg::OFF_RDATA, 32'h0);
  endtask
  function automatic logic [31:0] exp_rd(input logic [12:0] ad, input int k);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < k; i++)
      v = {v[23:0], mem[ad[5:0] + i]};
    return v;
  endfunction
  // bench driven link: bits msb first, select changes
  task automatic lbits(input logic [31:0] v, input int k);
    for (int i = k - 1; i >= 0; i--)
    begin
      lnk2.sdio_m_o <= v[i];
      repeat (4) @(posedge clk_i);
      lnk2.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      lnk2.sclk <= 1'b0;
    end
  endtask
  task automatic lsel(input logic v);
    repeat (4) @(posedge clk_i);
    lnk2.chip_select_n <= v;
  endtask
  // main sequence
  initial
  begin
    seed = 89329;
    n_fail = 0;
    compares = 0;
    rstn_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    lnk2.sclk = 1'b0;
    lnk2.chip_select_n = 1'b1;
    lnk2.sdio_m_o = 1'b0;
    lnk2.sdio_m_oe = 1'b1;
    for (int i = 0; i < 64; i++)
      mem[i] = (i == 9) ? 8'h01 : 8'h00;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    check({24'h0, clk_cfg_o, port_cfg_o}, 32'h0118);
    check({31'h0, stab_o}, 32'h1);
    xfer(1'b1, 2'h0, 13'h0009, 24'h0);
    check(q, 32'h01);
    xfer(1'b1, 2'h0, 13'h0001, 24'h0);
    check(q, {24'h0, ID});
    xfer(1'b1, 2'h0, 13'h0003, 24'h0);
    check(q, 32'h0);
    apb(1'b0, 12'h7F0, 32'h0);
    check({q[30:0], e}, 32'h1);
    xfer(1'b0, 2'h0, 13'h0009, 24'h000000);
    check({24'h0, clk_cfg_o}, 32'h01);
    xfer(1'b0, 2'h0, 13'h00FF, 24'h010000);
    check({23'h0, stab_o, clk_cfg_o}, 32'h000);
    mem[9] = 8'h00;
    for (int i = 0; i < 9; i++)
    begin
      nb = i % 3 + 1;
      r = $random(seed);
      a = 13'h0008 + 13'(r[15:0] % (39 - nb));
      if (i == 2)
        a = 13'h002B;
      xfer(1'b0, 2'(nb - 1), a, r[31:8]);
      for (int j = 0; j < nb; j++)
        mem[a[5:0] + j] = r[31 - 8 * j -: 8];
      xfer(1'b1, 2'(nb - 1), a, 24'h0);
      check(q, exp_rd(a, nb));
    end
    xfer(1'b0, 2'h0, 13'h00FF, 24'h010000);
    check({24'h0, clk_cfg_o}, {24'h0, mem[9]});
    xfer(1'b0, 2'h0, 13'h0000, 24'h5A0000);
    check({24'h0, port_cfg_o}, 32'h5A);
    apb(1'b1, scp_pkg::OFF_CFG, 32'h1);
    xfer(1'b1, 2'h0, 13'h0001, 24'h0);
    check(q, {24'h0, ID});
    // second device: abort, ignored clocks, streaming, stalled bytes
    lsel(1'b0);
    lbits(32'h0009, 16);
    lbits(32'h5, 4);
    lsel(1'b1);
    lbits(32'hFF, 8);
    lsel(1'b0);
    lbits(32'h6006, 16);
    lbits(32'h11223300, 32);
    lsel(1'b1);
    repeat (4) @(posedge clk_i);
    check({24'h0, clk_cfg2}, 32'h01);
    lsel(1'b0);
    lbits(32'h00FF01, 24);
    lsel(1'b1);
    repeat (4) @(posedge clk_i);
    check({23'h0, stab2, clk_cfg2}, 32'h000);
    lsel(1'b0);
    lbits(32'h2008, 16);
    lbits(32'h44, 8);
    lsel(1'b1);
    lbits(32'h0F, 8);
    lsel(1'b0);
    lbits(32'h01, 8);
    lsel(1'b1);
    lsel(1'b0);
    lbits(32'h00FF01, 24);
    lsel(1'b1);
    repeat (4) @(posedge clk_i);
    check({23'h0, stab2, clk_cfg2}, 32'h101);
    results();
  end
endmodule
